// [verification/pric_cpu_model.sv]
// Behavioural CPU that answers the core's request with acknowledge pairs.
// Assumes the core's registered outputs settle within 1 ns of ref_clk.
`default_nettype none
`timescale 1ns/1ps
module pric_cpu_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cpuInterruptRequest,
   input wire logic [7:0] readData,
   input wire logic dataOutEnable,
   input wire logic ackEnable,
   input wire logic [3:0] gap,
   output var logic interruptAcknowledge,
   output var logic [7:0] vecData,
   output var logic vecValid,
   output var int vecCount
);
   // ****************************************************************
   // Acknowledge pair, vector taken in the cycle after the second
   // ****************************************************************
   initial begin
      interruptAcknowledge = 1'b0;
      vecData = 8'h00;
      vecValid = 1'b0;
      vecCount = 0;
      forever begin
         @(posedge ref_clk);
         #1;
         if (reset_n && ackEnable && cpuInterruptRequest) begin
            interruptAcknowledge = 1'b1;
            @(posedge ref_clk);
            #1 interruptAcknowledge = 1'b0;
            // Slow CPU leaves idle cycles between the two
            repeat (gap) @(posedge ref_clk);
            #1 interruptAcknowledge = 1'b1;
            @(posedge ref_clk);
            #1 interruptAcknowledge = 1'b0;
            vecData = readData;
            vecValid = dataOutEnable;
            vecCount = vecCount + 1;
            repeat (2) @(posedge ref_clk);
         end
      end
   end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench of the priority interrupt controller core.
// Assumes pric_pkg, pric_core and the CPU model are compiled first.
`default_nettype none
`timescale 1ns/1ps
module tb;
   logic ref_clk;
   logic reset_n;
   logic [7:0] requestInputs;
   pric_pkg::pric_bus_type busReq;
   pric_pkg::pric_mode_type modeCfg;
   logic interruptAcknowledge;
   logic [7:0] readData;
   logic dataOutEnable;
   logic cpuInterruptRequest;
   logic ackEnable;
   logic [3:0] gap;
   logic [7:0] vecData;
   logic vecValid;
   int vecCount;
   int fails;
   int checked;
   int cycles;
   logic [31:0] rnd;
   logic [2:0] lvl;
   logic [7:0] mval;

   pric_core i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .requestInputs(requestInputs), .busReq(busReq),
      .interruptAcknowledge(interruptAcknowledge), .modeCfg(modeCfg),
      .readData(readData), .dataOutEnable(dataOutEnable),
      .cpuInterruptRequest(cpuInterruptRequest));

   pric_cpu_model i_cpu (.ref_clk(ref_clk), .reset_n(reset_n),
      .cpuInterruptRequest(cpuInterruptRequest), .readData(readData),
      .dataOutEnable(dataOutEnable), .ackEnable(ackEnable), .gap(gap),
      .interruptAcknowledge(interruptAcknowledge), .vecData(vecData),
      .vecValid(vecValid), .vecCount(vecCount));

   // ****************************************************************
   // Clock, timeout and shared tasks
   // ****************************************************************
   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         end_sim();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic end_sim();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic a, input logic [7:0] d);
      @(negedge ref_clk);
      busReq.write = 1'b1;
      busReq.lowAddressBit = a;
      busReq.data = d;
      @(negedge ref_clk);
      busReq.write = 1'b0;
   endtask

   task automatic rd(input logic a, input logic [7:0] exp);
      @(negedge ref_clk);
      busReq.read = 1'b1;
      busReq.lowAddressBit = a;
      @(negedge ref_clk);
      busReq.read = 1'b0;
      check8({7'h00, dataOutEnable}, 8'h01);
      check8(readData, exp);
   endtask

   task automatic pins(input logic [7:0] p);
      @(negedge ref_clk);
      requestInputs = p;
      // Synchroniser, edge detect and registered request
      repeat (6) @(negedge ref_clk);
   endtask

   task automatic ack_pair(input logic [3:0] g, input logic [2:0] l);
      int n;
      n = vecCount;
      gap = g;
      ackEnable = 1'b1;
      for (int i = 0; i < 60 && vecCount == n; i++)
         @(negedge ref_clk);
      ackEnable = 1'b0;
      check8({7'h00, vecValid}, 8'h01);
      check8(vecData, {modeCfg.vectorBase, l});
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      fails = 0;
      checked = 0;
      cycles = 0;
      rnd = 32'd75224;
      reset_n = 1'b0;
      requestInputs = 8'h00;
      busReq = '0;
      modeCfg = '0;
      ackEnable = 1'b0;
      gap = 4'h0;
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      reset_n = 1'b1;
      rd(1'b1, 8'h00);
      rd(1'b0, 8'h00);
      rnd = lfsr(rnd);
      mval = rnd[7:0];
      wr(1'b1, mval);
      rd(1'b1, mval);
      wr(1'b1, 8'h00);
      rnd = lfsr(rnd);
      lvl = rnd[2:0];
      modeCfg.vectorBase = rnd[12:8];
      pins(8'h01 << lvl);
      check8({7'h00, cpuInterruptRequest}, 8'h01);
      rd(1'b0, 8'h01 << lvl);
      ack_pair(4'h0, lvl);
      wr(1'b0, 8'h0b);
      rd(1'b0, 8'h01 << lvl);
      wr(1'b0, 8'h20);
      rd(1'b0, 8'h00);
      pins(8'h00);
      // Nesting: level 3 in service blocks 5, not 1
      pins(8'h08);
      ack_pair(4'h3, 3'h3);
      pins(8'h28);
      check8({7'h00, cpuInterruptRequest}, 8'h00);
      pins(8'h2a);
      check8({7'h00, cpuInterruptRequest}, 8'h01);
      ack_pair(4'h1, 3'h1);
      rd(1'b0, 8'h0a);
      wr(1'b0, 8'h20);
      rd(1'b0, 8'h08);
      wr(1'b0, 8'h63);
      rd(1'b0, 8'h00);
      // Poll write also clears read enable, so the status read returns zero
      wr(1'b0, 8'h0c);
      rd(1'b1, 8'h85);
      rd(1'b0, 8'h00);
      wr(1'b0, 8'h0b);
      rd(1'b0, 8'h20);
      wr(1'b0, 8'h65);
      pins(8'h00);
      // Lowest level 2 makes level 4 outrank level 1
      wr(1'b0, 8'hc2);
      pins(8'h12);
      wr(1'b0, 8'h0c);
      rd(1'b0, 8'h84);
      wr(1'b0, 8'h64);
      wr(1'b0, 8'hc7);
      pins(8'h00);
      modeCfg.autoCompletionMode = 1'b1;
      wr(1'b0, 8'h0b);
      pins(8'h40);
      ack_pair(4'h2, 3'h6);
      rd(1'b0, 8'h00);
      pins(8'h00);
      // Level mode: pending follows the pins both ways
      modeCfg.autoCompletionMode = 1'b0;
      modeCfg.levelTriggerSelect = 1'b1;
      wr(1'b0, 8'h0a);
      pins(8'h24);
      rd(1'b0, 8'h24);
      pins(8'h00);
      rd(1'b0, 8'h00);
      // Special mask: masked level 2 in service no longer blocks 5
      pins(8'h04);
      ack_pair(4'h0, 3'h2);
      wr(1'b1, 8'h04);
      wr(1'b0, 8'h68);
      pins(8'h24);
      check8({7'h00, cpuInterruptRequest}, 8'h01);
      wr(1'b0, 8'h20);
      wr(1'b0, 8'h0b);
      rd(1'b0, 8'h04);
      wr(1'b0, 8'h48);
      wr(1'b1, 8'h00);
      wr(1'b0, 8'h62);
      pins(8'h00);
      // Special nesting: slave level 3 re-enters while in service
      modeCfg.specialNestingMode = 1'b1;
      modeCfg.slaveLevels = 8'h08;
      pins(8'h08);
      ack_pair(4'h1, 3'h3);
      pins(8'h08);
      check8({7'h00, cpuInterruptRequest}, 8'h01);
      // Slave status zero, so the master gets its plain end
      wr(1'b0, 8'h20);
      rd(1'b0, 8'h00);
      pins(8'h00);
      end_sim();
   end
endmodule
`default_nettype wire

// [verilog/pric_core.sv]
// Eight-level priority interrupt controller core.
// Assumes bus strobes and acknowledge are one-cycle pulses on ref_clk,
// request pins asynchronous, mode bits static after configuration.
//
// Functional notes
// RULE_01: Read-enable clear: status reads return zero, select bit ignored.
// RULE_02: Read-enable set: select 0 reads pending, select 1 in-service.
// RULE_03: After a poll write the next read is a poll read, overriding all.
// RULE_04: Raise CPU request for an unmasked request outranking all in service.
// RULE_05: An active-high request input sets its pending bit.
// RULE_06: First acknowledge freezes resolution, sets in-service, clears pending.
// RULE_07: First acknowledge leaves the data bus undriven.
// RULE_08: Second acknowledge drives the 8-bit vector of the acknowledged level.
// RULE_09: CPU answers a request with two acknowledges, vector on the second.
// RULE_10: Auto completion does a non-specific end at the final acknowledge end.
// RULE_11: Nothing pending at first acknowledge: level 7 vector, no in-service.
// RULE_12: Specific end clears the in-service bit named by the low bits.
// RULE_13: Non-specific end clears the highest-priority in-service bit.
// RULE_14: Normal nesting blocks requests at and below the in-service level.
// RULE_15: Special nesting lets a slave level re-enter while in service.
// RULE_16: Software ends slave first, ends master only if slave status zero.
// RULE_17: Special mask mode: a mask bit blocks only its own level.
// RULE_18: Special mask mode: non-specific end skips masked in-service bits.
// RULE_19: Priority rotates from a named lowest level; reset lowest is 7.
// RULE_20: Rotation makes the serviced level lowest; commands set it directly.
// RULE_21: Poll byte: bit 7 pending, bits 6-3 zero, bits 2-0 level.
// RULE_22: Read with address bit high returns mask, low returns status.
// RULE_23: Edge mode latches rising edges; level mode follows the input.
// RULE_24: Mask resets to zero; writing a one masks that level.
// RULE_25: Priority command decoded only when data bits 4 and 3 are zero.
// RULE_26: All state is clocked and reset to post-initialization defaults.
`default_nettype none
`timescale 1ns/1ps
`include "pric_defines.svh"
module pric_core (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] requestInputs,
   input wire pric_pkg::pric_bus_type busReq,
   input wire logic interruptAcknowledge,
   input wire pric_pkg::pric_mode_type modeCfg,
   output logic [7:0] readData,
   output logic dataOutEnable,
   output logic cpuInterruptRequest
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [7:0] oneHot(input logic [2:0] lvl);
      oneHot = 8'h01 << lvl;
   endfunction

   // Zero is the highest rank
   function automatic logic [2:0] priRank(input logic [2:0] lvl,
                                          input logic [2:0] low);
      priRank = lvl - low - 3'h1;
   endfunction

   function automatic logic [7:0] eligibleMask(input logic [7:0] req,
                                               input logic topValid,
                                               input logic [2:0] top,
                                               input logic [2:0] low,
                                               input logic nestSpecial,
                                               input logic [7:0] slaves);
      logic [2:0] lvl;
      logic ok;
      eligibleMask = 8'h00;
      for (int i = 0; i < 8; i++) begin
         lvl = 3'(i);
         ok = !topValid || (priRank(lvl, low) < priRank(top, low)) ||
              (nestSpecial && slaves[i] && (lvl == top));
         eligibleMask[i] = req[i] & ok;
      end
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   logic [7:0] reqSync;
   logic [7:0] reqPrev_r;
   logic [7:0] irr_r, irr_nxt;
   logic [7:0] isr_r, isr_nxt;
   logic [7:0] mask_r, mask_nxt;
   logic [2:0] lowest_r, lowest_nxt;
   logic [2:0] ackLevel_r, ackLevel_nxt;
   logic rrEnable_r, rrEnable_nxt;
   logic rsSel_r, rsSel_nxt;
   logic smm_r, smm_nxt;
   logic pollPending_r, pollPending_nxt;
   logic rotAeoi_r, rotAeoi_nxt;
   logic [7:0] readData_nxt;
   logic dataOutEnable_nxt;
   logic cpu_interrupt_request_nxt;
   pric_pkg::pric_state_type state_r, state_nxt;

   pric_sync #(
      .WIDTH(8)
   ) u_reqSync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .asyncIn(requestInputs),
      .syncOut(reqSync)
   );

   // ****************************************************************
   // Command decode
   // ****************************************************************
   wire cmdWrite = busReq.write & ~busReq.lowAddressBit;
   wire maskWrite = busReq.write & busReq.lowAddressBit;
   wire [1:0] cmdKind = busReq.data[`PRIC_KIND_HI:`PRIC_KIND_LO];
   wire priCmd = cmdWrite & (cmdKind == `PRIC_KIND_PRIORITY); // [RULE_25]
   wire readCtl = cmdWrite & (cmdKind == `PRIC_KIND_READCTL);
   wire [2:0] priOp = busReq.data[`PRIC_OP_HI:`PRIC_OP_LO];
   wire [2:0] cmdLevel = busReq.data[`PRIC_LVL_HI:`PRIC_LVL_LO];
   wire opNs = (priOp == `PRIC_OP_NSEOI) | (priOp == `PRIC_OP_ROT_NSEOI);
   wire opSp = (priOp == `PRIC_OP_SEOI) | (priOp == `PRIC_OP_ROT_SEOI);
   wire opSetLow = (priOp == `PRIC_OP_SET_PRI) |
                   (priOp == `PRIC_OP_ROT_SEOI);

   // ****************************************************************
   // Priority resolution
   // ****************************************************************
   // In special mask mode, masked in-service levels neither block nor take a plain end
   wire [7:0] isrEff = smm_r ? (isr_r & ~mask_r) : isr_r; // [RULE_17] [RULE_18]
   wire isrFound;
   wire [2:0] isrTop;
   wire reqValid;
   wire [2:0] reqLevel;
   // A latched edge still needs the pin high when it is resolved
   wire [7:0] reqLive = irr_r & reqSync & ~mask_r; // [RULE_24]
   wire [7:0] eligible = eligibleMask(reqLive, isrFound, isrTop, lowest_r,
                                      modeCfg.specialNestingMode,
                                      modeCfg.slaveLevels); // [RULE_14] [RULE_15]

   pric_resolver u_isrRes (
      .reqVec(isrEff),
      .lowest(lowest_r),
      .found(isrFound),
      .level(isrTop)
   );

   pric_resolver u_reqRes (
      .reqVec(eligible),
      .lowest(lowest_r),
      .found(reqValid),
      .level(reqLevel)
   ); // [RULE_19]

   // ****************************************************************
   // Acknowledge and end-of-service
   // ****************************************************************
   wire stIdle = (state_r == pric_pkg::PRIC_IDLE);
   wire ackFirst = interruptAcknowledge & stIdle;
   wire ackSecond = interruptAcknowledge & (state_r == pric_pkg::PRIC_ARMED);
   wire pollRead = busReq.read & pollPending_r;
   wire takeLevel = (ackFirst | pollRead) & reqValid;
   wire [7:0] takeVec = takeLevel ? oneHot(reqLevel) : 8'h00; // [RULE_06]
   wire autoEoi = (state_r == pric_pkg::PRIC_VECTOR) &
                  modeCfg.autoCompletionMode; // [RULE_10]
   wire nsEoi = (priCmd & opNs) | autoEoi;
   wire [7:0] nsClr = (nsEoi & isrFound) ? oneHot(isrTop) : 8'h00; // [RULE_13]
   wire [7:0] spClr = (priCmd & opSp) ? oneHot(cmdLevel) : 8'h00; // [RULE_12]
   wire rotNs = (priCmd & (priOp == `PRIC_OP_ROT_NSEOI)) |
                (autoEoi & rotAeoi_r);
   wire [7:0] rise = reqSync & ~reqPrev_r;
   wire [7:0] vector = {modeCfg.vectorBase, ackLevel_r};

   // Taking a level wins over clearing it in the same cycle
   assign isr_nxt = (isr_r & ~(nsClr | spClr)) | takeVec;
   assign irr_nxt = modeCfg.levelTriggerSelect ? reqSync :
                    ((irr_r & ~takeVec) | rise); // [RULE_05] [RULE_23]
   assign mask_nxt = maskWrite ? busReq.data : mask_r; // [RULE_24]
   assign lowest_nxt = (rotNs & isrFound) ? isrTop :
                       (priCmd & opSetLow) ? cmdLevel : lowest_r; // [RULE_20]
   assign rotAeoi_nxt = (priCmd & (priOp == `PRIC_OP_ROT_AUTO_COMPLETION_MODE_SET)) ? 1'b1 :
                        (priCmd & (priOp == `PRIC_OP_ROT_AUTO_COMPLETION_MODE_CLR)) ? 1'b0 :
                        rotAeoi_r;
   assign ackLevel_nxt = !ackFirst ? ackLevel_r :
                         reqValid ? reqLevel : `PRIC_SPURIOUS_LEVEL; // [RULE_11]

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         pric_pkg::PRIC_IDLE: begin
            if (interruptAcknowledge) begin
               state_nxt = pric_pkg::PRIC_ARMED;
            end
         end
         pric_pkg::PRIC_ARMED: begin
            if (interruptAcknowledge) begin
               state_nxt = pric_pkg::PRIC_VECTOR;
            end
         end
         pric_pkg::PRIC_VECTOR: begin
            state_nxt = pric_pkg::PRIC_IDLE;
         end
         default: begin
            state_nxt = pric_pkg::PRIC_IDLE;
         end
      endcase
   end

   // Held low while an acknowledge is in flight: resolution is frozen
   assign cpu_interrupt_request_nxt = stIdle & ~interruptAcknowledge & reqValid; // [RULE_04]

   // ****************************************************************
   // Read control and read data
   // ****************************************************************
   assign rrEnable_nxt = readCtl ? busReq.data[`PRIC_RC_RR] : rrEnable_r;
   assign rsSel_nxt = (readCtl & busReq.data[`PRIC_RC_RR]) ?
                      busReq.data[`PRIC_RC_RS] : rsSel_r; // [RULE_01]
   assign smm_nxt = (readCtl & busReq.data[`PRIC_RC_ESMM]) ?
                    busReq.data[`PRIC_RC_SMM] : smm_r;
   assign pollPending_nxt = (readCtl & busReq.data[`PRIC_RC_POLL]) |
                            (pollPending_r & ~busReq.read);

   wire [7:0] pollByte = {reqValid, 4'h0, reqLevel}; // [RULE_21]
   wire [7:0] statusByte = !rrEnable_r ? 8'h00 :
                           rsSel_r ? isr_r : irr_r; // [RULE_01] [RULE_02]
   wire [7:0] readMux = pollPending_r ? pollByte :
                        busReq.lowAddressBit ? mask_r :
                        statusByte; // [RULE_03] [RULE_22]

   // First acknowledge drives nothing; second drives the vector
   assign readData_nxt = ackSecond ? vector :
                         busReq.read ? readMux : readData; // [RULE_08]
   assign dataOutEnable_nxt = ackSecond | busReq.read; // [RULE_07]

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         reqPrev_r <= 8'h00;
         irr_r <= 8'h00;
         isr_r <= 8'h00;
         mask_r <= `PRIC_MASK_RST;
         lowest_r <= `PRIC_LOWEST_RST;
         ackLevel_r <= `PRIC_SPURIOUS_LEVEL;
         state_r <= pric_pkg::PRIC_IDLE;
      end else begin // [RULE_26]
         reqPrev_r <= reqSync;
         irr_r <= irr_nxt;
         isr_r <= isr_nxt;
         mask_r <= mask_nxt;
         lowest_r <= lowest_nxt;
         ackLevel_r <= ackLevel_nxt;
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rrEnable_r <= `PRIC_RR_RST;
         rsSel_r <= `PRIC_RS_RST;
         smm_r <= 1'b0;
         pollPending_r <= 1'b0;
         rotAeoi_r <= 1'b0;
         readData <= `PRIC_VEC_RST;
         dataOutEnable <= 1'b0;
         cpuInterruptRequest <= 1'b0;
      end else begin
         rrEnable_r <= rrEnable_nxt;
         rsSel_r <= rsSel_nxt;
         smm_r <= smm_nxt;
         pollPending_r <= pollPending_nxt;
         rotAeoi_r <= rotAeoi_nxt;
         readData <= readData_nxt;
         dataOutEnable <= dataOutEnable_nxt;
         cpuInterruptRequest <= cpu_interrupt_request_nxt;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   wire statusRead = busReq.read & ~pollPending_r & ~busReq.lowAddressBit;

   sequence s_firstAck;
      interruptAcknowledge && stIdle;
   endsequence

   sequence s_secondAck;
      interruptAcknowledge && (state_r == pric_pkg::PRIC_ARMED);
   endsequence

   property p_readOff;
      statusRead && !rrEnable_r |=> dataOutEnable && (readData == 8'h00);
   endproperty
   a_readOff: assert property (p_readOff) // [RULE_01]
      else $error("status read returned data with read enable clear");

   property p_readIsr;
      statusRead && rrEnable_r && rsSel_r |=> readData == $past(isr_r);
   endproperty
   a_readIsr: assert property (p_readIsr) // [RULE_02]
      else $error("in-service read returned wrong value");

   property p_readIrr;
      statusRead && rrEnable_r && !rsSel_r |=> readData == $past(irr_r);
   endproperty
   a_readIrr: assert property (p_readIrr) // [RULE_02]
      else $error("pending read returned wrong value");

   property p_poll;
      pollRead && !readCtl && !ackSecond |=> (readData[6:3] == 4'h0) &&
         (readData[7] == $past(reqValid)) && !pollPending_r;
   endproperty
   a_poll: assert property (p_poll) // [RULE_03]
      else $error("poll read byte malformed");

   property p_maskRead;
      busReq.read && !pollPending_r && busReq.lowAddressBit && !ackSecond
         |=> readData == $past(mask_r);
   endproperty
   a_maskRead: assert property (p_maskRead) // [RULE_22]
      else $error("mask read returned wrong value");

   property p_cpu_interrupt_request;
      stIdle && !interruptAcknowledge && reqValid |=> cpuInterruptRequest;
   endproperty
   a_cpu_interrupt_request: assert property (p_cpu_interrupt_request) // [RULE_04]
      else $error("request not raised for eligible level");

   property p_ackSet;
      s_firstAck ##0 reqValid |=> isr_r[ackLevel_r] && !cpuInterruptRequest;
   endproperty
   a_ackSet: assert property (p_ackSet) // [RULE_06]
      else $error("first acknowledge did not set in-service");

   property p_ackQuiet;
      s_firstAck ##0 !busReq.read |=> !dataOutEnable;
   endproperty
   a_ackQuiet: assert property (p_ackQuiet) // [RULE_07]
      else $error("data driven during first acknowledge");

   property p_vector;
      s_secondAck |=> dataOutEnable && (readData == vector) ##1
         (state_r == pric_pkg::PRIC_IDLE);
   endproperty
   a_vector: assert property (p_vector) // [RULE_08]
      else $error("vector not driven after second acknowledge");

   property p_spurious;
      s_firstAck ##0 !reqValid |=> (ackLevel_r == `PRIC_SPURIOUS_LEVEL) &&
         (($past(isr_r) & 8'h80) == (isr_r & 8'h80));
   endproperty
   a_spurious: assert property (p_spurious) // [RULE_11]
      else $error("spurious acknowledge mishandled");

   property p_specEoi;
      priCmd && opSp && !takeLevel |=> !isr_r[$past(cmdLevel)];
   endproperty
   a_specEoi: assert property (p_specEoi) // [RULE_12]
      else $error("specific end left in-service bit set");

   property p_setLow;
      priCmd && opSetLow |=> lowest_r == $past(cmdLevel);
   endproperty
   a_setLow: assert property (p_setLow) // [RULE_20]
      else $error("lowest level not reassigned");

endmodule
`default_nettype wire

// [verilog/pric_defines.svh]
// Constants of the priority interrupt controller core.
// Assumes inclusion by bare name from the core's design files.
`ifndef PRIC_DEFINES_SVH
`define PRIC_DEFINES_SVH

// ****************************************************************
// Reset values
// ****************************************************************
`define PRIC_LOWEST_RST 3'h7
`define PRIC_MASK_RST 8'h00
`define PRIC_VEC_RST 8'h00
`define PRIC_RR_RST 1'b1
`define PRIC_RS_RST 1'b0
`define PRIC_SPURIOUS_LEVEL 3'h7

// ****************************************************************
// Command word fields
// ****************************************************************
`define PRIC_KIND_HI 4
`define PRIC_KIND_LO 3
`define PRIC_KIND_PRIORITY 2'h0
`define PRIC_KIND_READCTL 2'h1
`define PRIC_OP_HI 7
`define PRIC_OP_LO 5
`define PRIC_LVL_HI 2
`define PRIC_LVL_LO 0
`define PRIC_OP_ROT_AUTO_COMPLETION_MODE_CLR 3'h0
`define PRIC_OP_NSEOI 3'h1
`define PRIC_OP_NOP 3'h2
`define PRIC_OP_SEOI 3'h3
`define PRIC_OP_ROT_AUTO_COMPLETION_MODE_SET 3'h4
`define PRIC_OP_ROT_NSEOI 3'h5
`define PRIC_OP_SET_PRI 3'h6
`define PRIC_OP_ROT_SEOI 3'h7
`define PRIC_RC_ESMM 6
`define PRIC_RC_SMM 5
`define PRIC_RC_POLL 2
`define PRIC_RC_RR 1
`define PRIC_RC_RS 0

`endif

// [verilog/pric_pkg.sv]
// Types shared by the priority interrupt controller core.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pric_pkg;

   // ****************************************************************
   // Acknowledge sequencer states, Gray from IDLE to ARMED to VECTOR
   // ****************************************************************
   typedef enum logic [1:0] {
      PRIC_IDLE = 2'b00,
      PRIC_ARMED = 2'b01,
      PRIC_VECTOR = 2'b11
   } pric_state_type;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic write;
      logic read;
      logic lowAddressBit;
      logic [7:0] data;
   } pric_bus_type;

   typedef struct packed {
      logic levelTriggerSelect;
      logic autoCompletionMode;
      logic specialNestingMode;
      logic [7:0] slaveLevels;
      logic [4:0] vectorBase;
   } pric_mode_type;

endpackage
`default_nettype wire

// [verilog/pric_resolver.sv]
// Rotating priority encoder: highest-priority set bit of a vector.
// Assumes lowest names the lowest-priority level; purely combinational.
`default_nettype none
`timescale 1ns/1ps
module pric_resolver (
   input wire logic [7:0] reqVec,
   input wire logic [2:0] lowest,
   output logic found,
   output logic [2:0] level
);

   logic [2:0] idx;

   assign found = |reqVec;

   // Walks from lowest to highest so the last hit is the winner
   always_comb begin
      level = 3'h0;
      idx = 3'h0;
      for (int k = 7; k >= 0; k--) begin
         idx = lowest + 3'(k) + 3'h1;
         if (reqVec[idx]) begin
            level = idx;
         end
      end
   end

endmodule
`default_nettype wire

// [verilog/pric_sync.sv]
// Two-stage synchroniser for the request pins.
// Assumes inputs asynchronous to ref_clk, held long enough to sample.
`default_nettype none
`timescale 1ns/1ps
module pric_sync #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= '0;
         syncOut <= '0;
      end else begin
         meta_r <= asyncIn;
         syncOut <= meta_r;
      end
   end

endmodule
`default_nettype wire
